// >>> hdl/ipf_cfg.svh
// Register offsets, field positions and reset values of the priority field block.
// Assumes inclusion by bare name from the block module and the bench.
`ifndef IPF_CFG_SVH
`define IPF_CFG_SVH

// Byte offsets of the four priority registers on the register bus.
`define IPF_OFF_CHG_CMP_I2C1 4'h0
`define IPF_OFF_EXTINT1 4'h4
`define IPF_OFF_TMR4_CMP 4'h8
`define IPF_OFF_UART2_EXT2_TMR5 4'hC

// Low bit of each three-bit field position within a register.
`define IPF_POS_HI 12
`define IPF_POS_MH 8
`define IPF_POS_ML 4
`define IPF_POS_LO 0

// Reset value of every implemented field: level 4.
`define IPF_FIELD_RST 3'h4

// Implemented-bit masks of the four registers.
`define IPF_MASK_CHG_CMP_I2C1 16'h7777
`define IPF_MASK_EXTINT1 16'h0007
`define IPF_MASK_TMR4_CMP 16'h7770
`define IPF_MASK_UART2_EXT2_TMR5 16'h7777

// Register reset images derived from the field reset value.
`define IPF_RST_CHG_CMP_I2C1 16'h4444
`define IPF_RST_EXTINT1 16'h0004
`define IPF_RST_TMR4_CMP 16'h4440
`define IPF_RST_UART2_EXT2_TMR5 16'h4444

// AXI response codes.
`define IPF_RESP_OKAY 2'h0
`define IPF_RESP_SLVERR 2'h2

`endif

// >>> hdl/ipf_pkg.sv
// Types shared by the priority field block.
// Uses no macro from the configuration header.
package ipf_pkg;

	// One three-bit priority code; 0 disables, 1..7 is the level.
	typedef logic [2:0] ipf_prio_t;

	// All twelve priority fields as seen by the arbitration logic.
	typedef struct packed {
		ipf_prio_t change_notify_prio;
		ipf_prio_t comparator_prio;
		ipf_prio_t i2c_one_master_prio;
		ipf_prio_t i2c_one_slave_prio;
		ipf_prio_t external_irq_one_prio;
		ipf_prio_t timer_four_prio;
		ipf_prio_t compare_four_prio;
		ipf_prio_t compare_three_prio;
		ipf_prio_t uart_two_tx_prio;
		ipf_prio_t uart_two_rx_prio;
		ipf_prio_t external_irq_two_prio;
		ipf_prio_t timer_five_prio;
	} ipf_fields_t;

	// Read-side channel state of the slave.
	typedef enum logic [0:0] {
		IPF_RD_IDLE = 1'b0,
		IPF_RD_RESP = 1'b1
	} ipf_rd_state_t;

endpackage : ipf_pkg

// >>> hdl/ipf_regs.sv
// Four 16-bit interrupt priority registers behind an AXI4-Lite slave.
// Assumes one clock, asynchronous active-high reset, and a master keeping one
// write and one read in flight at a time.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ipf_cfg.svh"

module ipf_regs
(
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite write address and data.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address and data.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Priority fields toward the arbitration logic.
	output ipf_pkg::ipf_fields_t prio_fields,
	// Per-source enable: high while the field is nonzero.
	output logic [11:0] source_enabled
);

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// Maps an address to its register index; returns 3'h4 when unmapped.
	function automatic logic [2:0] ipf_index(input logic [3:0] addr);
		unique case (addr)
			`IPF_OFF_CHG_CMP_I2C1: ipf_index = 3'h0;
			`IPF_OFF_EXTINT1: ipf_index = 3'h1;
			`IPF_OFF_TMR4_CMP: ipf_index = 3'h2;
			`IPF_OFF_UART2_EXT2_TMR5: ipf_index = 3'h3;
			default: ipf_index = 3'h4;
		endcase
	endfunction : ipf_index

	// Implemented-bit mask of a register index; unmapped gives no bits.
	function automatic logic [15:0] ipf_mask(input logic [2:0] idx);
		unique case (idx)
			3'h0: ipf_mask = `IPF_MASK_CHG_CMP_I2C1;
			3'h1: ipf_mask = `IPF_MASK_EXTINT1;
			3'h2: ipf_mask = `IPF_MASK_TMR4_CMP;
			3'h3: ipf_mask = `IPF_MASK_UART2_EXT2_TMR5;
			default: ipf_mask = 16'h0000;
		endcase
	endfunction : ipf_mask

	// Reset image of a register index; every implemented field starts at level four.
	function automatic logic [15:0] ipf_reset(input logic [2:0] idx);
		unique case (idx)
			3'h0: ipf_reset = `IPF_RST_CHG_CMP_I2C1;
			3'h1: ipf_reset = `IPF_RST_EXTINT1;
			3'h2: ipf_reset = `IPF_RST_TMR4_CMP;
			3'h3: ipf_reset = `IPF_RST_UART2_EXT2_TMR5;
			default: ipf_reset = 16'h0000;
		endcase
	endfunction : ipf_reset

	////////////////////////////////////////////////////////////////////////
	// Register storage.

	logic [15:0] regs_q [4];
	logic aw_held_q;
	logic [3:0] aw_addr_q;
	logic w_held_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic [2:0] wr_idx;
	logic [15:0] wr_bits;
	logic [15:0] wr_lane_mask;

	// A write commits once address and data are both held and no response is pending.
	assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
	assign wr_idx = ipf_index(aw_addr_q);
	assign wr_lane_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
	assign wr_bits = w_data_q[15:0];

	// Each register keeps only its implemented bits, honouring byte strobes.
	for (genvar g = 0; g < 4; g++)
	begin : g_reg
		always_ff @(posedge clk or posedge reset)
		begin
			if (reset)
			begin
				regs_q[g] <= ipf_reset(3'(g));
			end
			else if (wr_fire && wr_idx == 3'(g))
			begin
				// implemented bits keep what was written.
				regs_q[g] <= (regs_q[g] & ~wr_lane_mask) | (wr_bits & wr_lane_mask & ipf_mask(3'(g)));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write channels: address and data are taken independently.

	assign s_axi_awready = !aw_held_q;
	assign s_axi_wready = !w_held_q;

	// Address hold register; freed when the write commits.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end
		else if (wr_fire)
		begin
			aw_held_q <= 1'b0;
		end
	end

	// Data hold register; freed when the write commits.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end
		else if (wr_fire)
		begin
			w_held_q <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer SLVERR and change nothing.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IPF_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_idx == 3'h4) ? `IPF_RESP_SLVERR : `IPF_RESP_OKAY;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel.

	ipf_pkg::ipf_rd_state_t rd_state_q;
	logic [2:0] rd_idx;

	assign s_axi_arready = (rd_state_q == ipf_pkg::IPF_RD_IDLE);
	assign s_axi_rvalid = (rd_state_q == ipf_pkg::IPF_RD_RESP);
	assign rd_idx = ipf_index(s_axi_araddr);

	// Read state machine: one read in flight.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rd_state_q <= ipf_pkg::IPF_RD_IDLE;
		end
		else
		begin
			unique case (rd_state_q)
				ipf_pkg::IPF_RD_IDLE: if (s_axi_arvalid) rd_state_q <= ipf_pkg::IPF_RD_RESP;
				ipf_pkg::IPF_RD_RESP: if (s_axi_rready) rd_state_q <= ipf_pkg::IPF_RD_IDLE;
			endcase
		end
	end

	// Read data capture; bits above the field layout read as zero.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `IPF_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			// masked read returns zero in unimplemented bits.
			s_axi_rdata <= (rd_idx == 3'h4) ? 32'h00000000 : {16'h0000, regs_q[rd_idx[1:0]] & ipf_mask(rd_idx)};
			s_axi_rresp <= (rd_idx == 3'h4) ? `IPF_RESP_SLVERR : `IPF_RESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field outputs to the arbitration logic.

	assign prio_fields.change_notify_prio = regs_q[0][`IPF_POS_HI +: 3];
	assign prio_fields.comparator_prio = regs_q[0][`IPF_POS_MH +: 3];
	assign prio_fields.i2c_one_master_prio = regs_q[0][`IPF_POS_ML +: 3];
	assign prio_fields.i2c_one_slave_prio = regs_q[0][`IPF_POS_LO +: 3];
	assign prio_fields.external_irq_one_prio = regs_q[1][`IPF_POS_LO +: 3];
	assign prio_fields.timer_four_prio = regs_q[2][`IPF_POS_HI +: 3];
	assign prio_fields.compare_four_prio = regs_q[2][`IPF_POS_MH +: 3];
	assign prio_fields.compare_three_prio = regs_q[2][`IPF_POS_ML +: 3];
	assign prio_fields.uart_two_tx_prio = regs_q[3][`IPF_POS_HI +: 3];
	assign prio_fields.uart_two_rx_prio = regs_q[3][`IPF_POS_MH +: 3];
	assign prio_fields.external_irq_two_prio = regs_q[3][`IPF_POS_ML +: 3];
	assign prio_fields.timer_five_prio = regs_q[3][`IPF_POS_LO +: 3];

	// Source enables, MSB first in struct order; zero code masks the source.
	for (genvar s = 0; s < 12; s++)
	begin : g_en
		assign source_enabled[s] = |prio_fields[s*3 +: 3];
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	// Write commit condition, the same as wr_fire.
	sequence s_commit;
		aw_held_q && w_held_q && !s_axi_bvalid;
	endsequence

	chk_unimpl_zero: assert property (@(posedge clk) disable iff (reset)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[15] == 1'b0 && s_axi_rdata[11] == 1'b0)
		else $error("Unimplemented bits read nonzero.");

	chk_ext1_mask: assert property (@(posedge clk) disable iff (reset)
		(regs_q[1] & ~`IPF_MASK_EXTINT1) == 16'h0000)
		else $error("Second register holds unimplemented bits.");

	chk_tmr4_low: assert property (@(posedge clk) disable iff (reset)
		regs_q[2][3:0] == 4'h0)
		else $error("Third register low nibble not zero.");

	chk_write_back: assert property (@(posedge clk) disable iff (reset)
		s_commit ##0 (wr_idx == 3'h3 && w_strb_q[1:0] == 2'h3) |=> regs_q[3] == ($past(w_data_q[15:0]) & 16'h7777))
		else $error("Written value not stored.");

	chk_bresp_follow: assert property (@(posedge clk) disable iff (reset)
		s_commit |=> s_axi_bvalid)
		else $error("No write response after commit.");

	chk_disable_zero: assert property (@(posedge clk) disable iff (reset)
		prio_fields.timer_five_prio == 3'h0 |-> !source_enabled[0])
		else $error("Zero code leaves source enabled.");

	chk_level_pass: assert property (@(posedge clk) disable iff (reset)
		prio_fields.change_notify_prio != 3'h0 |-> source_enabled[11])
		else $error("Nonzero level not enabled.");

	chk_field_map: assert property (@(posedge clk) disable iff (reset)
		prio_fields.comparator_prio == regs_q[0][10:8] && prio_fields.uart_two_rx_prio == regs_q[3][10:8])
		else $error("Field mapping broken.");

	chk_reset_level: assert property (@(posedge clk)
		$fell(reset) |-> prio_fields.external_irq_one_prio == 3'h4 && prio_fields.timer_four_prio == 3'h4)
		else $error("Fields not at level four after reset.");

	chk_read_resp: assert property (@(posedge clk) disable iff (reset)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read not answered next cycle.");

endmodule : ipf_regs

// >>> verif/tb_interrupt_priority_fields.sv
// Self-checking bench for the priority field registers behind an AXI4-Lite slave.
// Assumes the design header sits in the include path; the bench waits for every answer, bounded.
`timescale 1ns/10ps
`include "ipf_cfg.svh"
module tb_interrupt_priority_fields;
	logic clk, reset, awv, wv, bv, br, arv, rv, rr, awr, wr, arr;
	logic [3:0] awa, ara, ws;
	logic [31:0] wd, rd;
	logic [1:0] bresp, rresp, resp;
	logic [35:0] pf;
	logic [11:0] en;
	ipf_pkg::ipf_fields_t fields;
	int miscompares, cmp_count;
	logic [15:0] mdl[4];
	logic [31:0] rd_q;
	logic [15:0] msk[4] = '{16'h7777, 16'h0007, 16'h7770, 16'h7777};
	logic [3:0] off[4] = '{`IPF_OFF_CHG_CMP_I2C1, `IPF_OFF_EXTINT1, `IPF_OFF_TMR4_CMP, `IPF_OFF_UART2_EXT2_TMR5};
	assign pf = fields;

	ipf_regs u_ipf_regs (.clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .prio_fields(fields),
		.source_enabled(en));

	// Free-running 50 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, compare and bus tasks.
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// One compare; the printed line carries time and what was compared.
	task automatic chk(input logic [35:0] g, input logic [35:0] e, input string m);
		cmp_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk

	// A used-up wait bound is a mismatch and ends the run at once.
	task automatic hang();
		miscompares++;
		$display("[ERR] %0t bus wait ran out", $time);
		results();
	endtask : hang

	// Address and data are offered together; each is dropped right after its own handshake edge.
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw, pa, pw, hit;
		int n;
		awa <= a; wd <= d; ws <= s; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; hit = 1'b0; pa = 1'b1; pw = 1'b1;
		for (n = 0; n < 50 && (pa || pw); n++)
		begin
			@(negedge clk);
			ta = pa & awr;
			tw = pw & wr;
			@(posedge clk);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			pa = pa & ~ta;
			pw = pw & ~tw;
		end
		for (n = 0; n < 50 && !hit; n++)
		begin
			@(negedge clk);
			hit = bv;
			resp = bresp;
			@(posedge clk);
		end
		// One edge passes so that a following call never raises bready in the same time step.
		br <= 1'b0;
		@(posedge clk);
		if (!hit || pa || pw) hang();
	endtask : axi_wr

	// Read: address until arready edge, rready held until the data edge.
	task automatic axi_rd(input logic [3:0] a);
		logic hit, ta;
		int n;
		ara <= a; arv <= 1'b1; rr <= 1'b1; hit = 1'b0; ta = 1'b0;
		for (n = 0; n < 50 && !ta; n++)
		begin
			@(negedge clk);
			ta = arr;
			@(posedge clk);
		end
		arv <= 1'b0;
		for (n = 0; n < 50 && !hit; n++)
		begin
			@(negedge clk);
			hit = rv;
			resp = rresp;
			rd_q = rd;
			@(posedge clk);
		end
		// One edge passes so that a following call never raises rready in the same time step.
		rr <= 1'b0;
		@(posedge clk);
		if (!hit || !ta) hang();
	endtask : axi_rd

	// Model write: byte lanes 0 and 1 only, unassigned bits never stored.
	task automatic wr_m(input int i, input logic [31:0] d, input logic [3:0] s);
		logic [15:0] v;
		v = mdl[i];
		if (s[0]) v[7:0] = d[7:0];
		if (s[1]) v[15:8] = d[15:8];
		mdl[i] = v & msk[i];
		axi_wr(off[i], d, s);
		chk(resp, `IPF_RESP_OKAY, "bresp");
	endtask : wr_m

	// Reads every register, then the field and enable outputs against the model.
	task automatic check_all();
		logic [15:0] m[4];
		logic [35:0] e;
		logic [11:0] ee;
		foreach (mdl[i])
		begin
			m[i] = mdl[i];
			axi_rd(off[i]);
			chk({resp, rd_q}, {`IPF_RESP_OKAY, 16'h0000, m[i]}, "read");
		end
		e = {m[0][14:12], m[0][10:8], m[0][6:4], m[0][2:0], m[1][2:0], m[2][14:12], m[2][10:8], m[2][6:4],
			m[3][14:12], m[3][10:8], m[3][6:4], m[3][2:0]};
		for (int k = 0; k < 12; k++) ee[k] = |e[3*k+:3];
		chk(pf, e, "fields");
		chk(en, ee, "enables");
	endtask : check_all

	// Reset image per field is code four; lower fields only where implemented.
	task automatic do_reset();
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		foreach (mdl[i]) mdl[i] = msk[i] & 16'h4444;
		@(posedge clk);
	endtask : do_reset

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		{awv, wv, br, arv, rr} = '0;
		{awa, ara, ws, wd} = '0;
		miscompares = 0;
		cmp_count = 0;
		void'($urandom(63004));
		do_reset();
		check_all();
		foreach (mdl[i]) wr_m(i, 32'hFFFFFFFF, 4'hF);
		check_all();
		for (int c = 0; c < 8; c++)
		begin
			foreach (mdl[i]) wr_m(i, {16'hFFFF, {4{1'b0, c[2:0]}}}, 4'h3);
			check_all();
		end
		for (int n = 0; n < 24; n++)
		begin
			wr_m($urandom % 4, $urandom, 4'($urandom));
			check_all();
		end
		// Unaligned address decodes to no register: error, no store, zero data.
		axi_wr(4'h2, 32'hFFFFFFFF, 4'hF);
		chk(resp, `IPF_RESP_SLVERR, "bad wr");
		axi_rd(4'h2);
		chk({resp, rd_q}, {`IPF_RESP_SLVERR, 32'h00000000}, "bad rd");
		check_all();
		do_reset();
		check_all();
		results();
	end
endmodule : tb_interrupt_priority_fields
